// ---- core/mccrtc_main_clock_rtc.sv ----
// Main clock controller: CPU prescaler, clock out, time base and beeper.
//
// Overview of operation
// - Slow divider field selects CPU divide by 2, 4, 8 or 16.
// - Slow select clear gives oscillator clock; set gives divided clock.
// - Clock-out select drives oscillator clock divided by 2 on the clock-out pin.
// - Clock-out stops toggling while in Active Halt.
// - Time base field picks period 16000, 32000, 80000 or 200000 cycles.
// - A new time base takes effect only at the end of the period.
// - Each elapsed period sets the overflow flag in bit 0.
// - Reading the control status register clears the flag; no write sets it.
// - Interrupt request while overflow flag and its enable are both set.
// - Halt with overflow enable set enters Active Halt, else full Halt.
// - Time base interrupt wakes Wait and Active Halt, not full Halt.
// - Active Halt keeps the counter running, registers hold.
// - Full Halt freezes counter and registers until a capable wake.
// - Beep field selects off, about 2 kHz, 1 kHz or 500 Hz square wave.
// - Beep keeps running in Active Halt.
// - Beep register bit 3 goes to the converter as sample stretch.
// - Beep register bit 2 goes to the converter as interrupt enable.
`include "mccrtc_cfg.svh"

module mccrtc_main_clock_rtc
    import mccrtc_pkg::*;
#(
    parameter int TB_W            = 18,
    parameter int TB_PERIOD0      = `MCC_TB_PERIOD0,
    parameter int TB_PERIOD1      = `MCC_TB_PERIOD1,
    parameter int TB_PERIOD2      = `MCC_TB_PERIOD2,
    parameter int TB_PERIOD3      = `MCC_TB_PERIOD3,
    parameter int BEEP_HALF1      = `MCC_BEEP_HALF1,
    parameter int BEEP_HALF2      = `MCC_BEEP_HALF2,
    parameter int BEEP_HALF3      = `MCC_BEEP_HALF3
) (
    // Clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // AXI4-Lite write address and data
    input  wire logic [`MCC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // AXI4-Lite read
    input  wire logic [`MCC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // Power mode commands from the core
    input  wire mccrtc_pwr_cmd_t        pwr_cmd,
    // Clock outputs
    output logic                        cpu_clk_en,
    output logic                        clock_out_pin_o,
    output logic                        clock_out_pin_oe,
    output logic                        beep_pin_o,
    output logic                        beep_pin_oe,
    // Status and side controls
    output logic                        overflow_irq,
    output logic                        active_halt,
    output logic                        full_halt,
    output logic                        adc_sample_stretch,
    output logic                        adc_irq_enable
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    mccrtc_ccs_t   ccs_reg;
    mccrtc_beep_t  beep_reg;
    mccrtc_power_t pwr_reg;
    mccrtc_power_t pwr_next;
    logic [1:0]    tb_act_reg;
    logic [3:0]    pre_reg;
    logic          cpu_en_reg;
    logic          clk_out_reg;
    logic          irq_reg;
    logic          aw_hold_reg;
    logic          w_hold_reg;
    logic [`MCC_ADDR_W-1:0] awaddr_reg;
    logic [31:0]   wdata_reg;
    logic [3:0]    wstrb_reg;
    logic          bvalid_reg;
    logic          rvalid_reg;
    logic [31:0]   rdata_reg;
    logic [1:0]    bresp_reg;
    logic [1:0]    rresp_reg;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic          wr_fire;
    logic          rd_fire;
    logic          wr_ccs;
    logic          wr_beep;
    logic          wr_ok;
    logic          rd_ccs;
    logic          rd_beep;
    logic          rd_ok;
    logic          regs_frozen;
    logic [31:0]   rd_word;

    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // Registers hold in either halt; a bus access then still answers.
    assign regs_frozen = (pwr_reg == MCCRTC_AHALT)
                      || (pwr_reg == MCCRTC_HALT);

    assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
    assign wr_ccs  = awaddr_reg == {`MCC_IDX_CCS, 2'b00};
    assign wr_beep = awaddr_reg == {`MCC_IDX_BEEP, 2'b00};
    assign wr_ok   = wr_ccs || wr_beep;
    assign rd_fire = s_axi_arvalid && !rvalid_reg;
    assign rd_ccs  = s_axi_araddr == {`MCC_IDX_CCS, 2'b00};
    assign rd_beep = s_axi_araddr == {`MCC_IDX_BEEP, 2'b00};
    assign rd_ok   = rd_ccs || rd_beep;
    assign rd_word = rd_ccs  ? {24'h00_0000, ccs_reg} :
                     rd_beep ? {24'h00_0000, beep_reg} : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            awaddr_reg  <= '0;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_ok ? 2'b00 : 2'b10;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= 2'b00;
        end else if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_word;
            rresp_reg  <= rd_ok ? 2'b00 : 2'b10;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Power mode tracking
    // ------------------------------------------------------------------
    logic tb_run;
    logic tb_wrap;
    logic tb_last;
    logic [TB_W-1:0] tb_half;

    always_comb begin
        pwr_next = pwr_reg;
        unique case (pwr_reg)
            MCCRTC_RUN: begin
                if (pwr_cmd.halt_req)
                    pwr_next = ccs_reg.overflow_irq_enable
                             ? MCCRTC_AHALT : MCCRTC_HALT;
                else if (pwr_cmd.wait_req)
                    pwr_next = MCCRTC_WAIT;
            end
            MCCRTC_WAIT: begin
                if (pwr_cmd.wake_req || irq_reg)
                    pwr_next = MCCRTC_RUN;
            end
            MCCRTC_AHALT: begin
                if (pwr_cmd.wake_halt || pwr_cmd.wake_req || irq_reg)
                    pwr_next = MCCRTC_RUN;
            end
            MCCRTC_HALT: begin
                // The time base cannot raise a request here: it is frozen.
                if (pwr_cmd.wake_halt)
                    pwr_next = MCCRTC_RUN;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            pwr_reg <= MCCRTC_RUN;
        else
            pwr_reg <= pwr_next;
    end

    // ------------------------------------------------------------------
    // Control status and beep registers
    // ------------------------------------------------------------------
    logic oif_clear;

    assign oif_clear = rd_fire && rd_ccs;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ccs_reg  <= `MCC_CCS_RESET;
            beep_reg <= `MCC_BEEP_RESET;
        end else begin
            if (wr_fire && wr_ccs && wstrb_reg[0] && !regs_frozen)
                ccs_reg[7:1] <= wdata_reg[7:1];
            if (wr_fire && wr_beep && wstrb_reg[0] && !regs_frozen)
                beep_reg <= {4'h0, wdata_reg[3:0]};
            // Set beats the read clear.
            if (tb_wrap)
                ccs_reg.overflow_flag <= 1'b1;
            else if (oif_clear)
                ccs_reg.overflow_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------------
    // The selection in use is sampled only at wrap to avoid a time shift.
    assign tb_run  = (pwr_reg != MCCRTC_HALT);
    assign tb_half = (tb_act_reg == 2'b00) ? TB_W'(TB_PERIOD0) :
                     (tb_act_reg == 2'b01) ? TB_W'(TB_PERIOD1) :
                     (tb_act_reg == 2'b10) ? TB_W'(TB_PERIOD2) :
                                             TB_W'(TB_PERIOD3);

    mccrtc_divider #(
        .CNT_W       (TB_W)
    ) u_time_base (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .run         (tb_run),
        .enable      (1'b1),
        .half_period (tb_half),
        .wave        (),
        .wrap        (tb_wrap)
    );

    assign tb_last = tb_wrap;

    always_ff @(posedge aclk) begin
        if (!aresetn)
            tb_act_reg <= 2'b00;
        else if (tb_last)
            tb_act_reg <= ccs_reg.time_base_sel;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            irq_reg <= 1'b0;
        else
            irq_reg <= ccs_reg.overflow_flag
                    && ccs_reg.overflow_irq_enable;
    end

    // ------------------------------------------------------------------
    // CPU prescaler and clock out
    // ------------------------------------------------------------------
    logic [3:0] pre_mask;
    logic       pre_tick;

    assign pre_mask = (ccs_reg.slow_divider_sel == 2'b00) ? 4'h1 :
                      (ccs_reg.slow_divider_sel == 2'b01) ? 4'h3 :
                      (ccs_reg.slow_divider_sel == 2'b10) ? 4'h7 :
                                                            4'hF;
    assign pre_tick = (pre_reg & pre_mask) == pre_mask;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_reg     <= 4'h0;
            cpu_en_reg  <= 1'b1;
            clk_out_reg <= 1'b0;
        end else begin
            pre_reg     <= pre_reg + 4'h1;
            cpu_en_reg  <= !ccs_reg.slow_mode_select || pre_tick;
            clk_out_reg <= ccs_reg.clock_out_select
                        && (pwr_reg != MCCRTC_AHALT)
                        && !clk_out_reg;
        end
    end

    // ------------------------------------------------------------------
    // Beeper
    // ------------------------------------------------------------------
    logic [13:0] beep_half;
    logic        beep_wave;
    logic        beep_on;

    assign beep_on   = beep_reg.beep_tone_sel != 2'b00;
    assign beep_half = (beep_reg.beep_tone_sel == 2'b01) ? 14'(BEEP_HALF1) :
                       (beep_reg.beep_tone_sel == 2'b10) ? 14'(BEEP_HALF2) :
                                                           14'(BEEP_HALF3);

    // Runs in every mode except full halt, where the oscillator stops.
    mccrtc_divider #(
        .CNT_W       (14)
    ) u_beep (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .run         (tb_run),
        .enable      (beep_on),
        .half_period (beep_half),
        .wave        (beep_wave),
        .wrap        ()
    );

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clock_out_pin_oe   <= 1'b0;
            beep_pin_o         <= 1'b0;
            beep_pin_oe        <= 1'b0;
            active_halt        <= 1'b0;
            full_halt          <= 1'b0;
            adc_sample_stretch <= 1'b0;
            adc_irq_enable     <= 1'b0;
        end else begin
            clock_out_pin_oe   <= ccs_reg.clock_out_select;
            beep_pin_o         <= beep_wave;
            beep_pin_oe        <= beep_on;
            active_halt        <= pwr_next == MCCRTC_AHALT;
            full_halt          <= pwr_next == MCCRTC_HALT;
            adc_sample_stretch <= beep_reg.adc_sample_stretch;
            adc_irq_enable     <= beep_reg.adc_irq_enable;
        end
    end

    assign cpu_clk_en      = cpu_en_reg;
    assign clock_out_pin_o = clk_out_reg;
    assign overflow_irq    = irq_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_flag_sets_on_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        tb_wrap |=> ccs_reg.overflow_flag)
        else $error("overflow flag not set after wrap");
    a_read_clears_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        oif_clear && !tb_wrap |=> !ccs_reg.overflow_flag)
        else $error("read did not clear flag");
    a_irq_follows_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        ccs_reg.overflow_flag && ccs_reg.overflow_irq_enable |=> irq_reg)
        else $error("irq missing");
    a_halt_entry_kind: assert property (@(posedge aclk) disable iff (!aresetn)
        pwr_reg == MCCRTC_RUN && pwr_cmd.halt_req
        |=> pwr_reg == (ccs_reg.overflow_irq_enable ? MCCRTC_AHALT
                        : MCCRTC_HALT) || $past(wr_fire))
        else $error("wrong halt mode");
    a_halt_no_rtc_wake: assert property (@(posedge aclk) disable iff (!aresetn)
        pwr_reg == MCCRTC_HALT && !pwr_cmd.wake_halt |=> pwr_reg == MCCRTC_HALT)
        else $error("left halt without capable wake");
    a_halt_freezes_tb: assert property (@(posedge aclk) disable iff (!aresetn)
        pwr_reg == MCCRTC_HALT |-> !tb_wrap)
        else $error("time base ran in halt");
    a_clkout_stops: assert property (@(posedge aclk) disable iff (!aresetn)
        pwr_reg == MCCRTC_AHALT |=> !clk_out_reg)
        else $error("clock out toggled in active halt");
    a_fast_mode_clk: assert property (@(posedge aclk) disable iff (!aresetn)
        !ccs_reg.slow_mode_select |=> cpu_en_reg)
        else $error("cpu clock gated in normal mode");
    a_beep_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
        beep_reg.reserved == 4'h0)
        else $error("reserved beep bits set");
    c_overflow_read: cover property (@(posedge aclk) tb_wrap ##[1:20] oif_clear);
    c_active_halt: cover property (@(posedge aclk) pwr_reg == MCCRTC_AHALT);
    c_wake_irq: cover property (@(posedge aclk)
        pwr_reg == MCCRTC_AHALT && irq_reg ##1 pwr_reg == MCCRTC_RUN);

endmodule

// ---- include/mccrtc_cfg.svh ----
// Register offsets, field positions, reset values and timing counts.
`ifndef MCCRTC_CFG_SVH
`define MCCRTC_CFG_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
// Printed offsets 2C and 2D are not both multiples of four: they are indices.
`define MCC_IDX_CCS      8'h2C
`define MCC_IDX_BEEP     8'h2D
`define MCC_ADDR_W       10
`define MCC_CCS_RESET    8'h00
`define MCC_BEEP_RESET   8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MCC_CCS_CLKOUT   7
`define MCC_CCS_DIV_HI   6
`define MCC_CCS_DIV_LO   5
`define MCC_CCS_SLOW     4
`define MCC_CCS_TB_HI    3
`define MCC_CCS_TB_LO    2
`define MCC_CCS_OIE      1
`define MCC_CCS_OIF      0
`define MCC_BEEP_STRETCH 3
`define MCC_BEEP_ADCIE   2
`define MCC_BEEP_TONE_HI 1
`define MCC_BEEP_TONE_LO 0

// ----------------------------------------------------------------------
// Timing counts in oscillator cycles
// ----------------------------------------------------------------------
`define MCC_TB_PERIOD0   16000
`define MCC_TB_PERIOD1   32000
`define MCC_TB_PERIOD2   80000
`define MCC_TB_PERIOD3   200000
// Half periods of the tones with an 8 MHz oscillator (2k, 1k, 500 Hz).
`define MCC_BEEP_HALF1   2000
`define MCC_BEEP_HALF2   4000
`define MCC_BEEP_HALF3   8000

`endif

// ---- include/mccrtc_pkg.sv ----
// Types shared by the main clock controller files.
package mccrtc_pkg;

    typedef enum logic [1:0] {
        MCCRTC_RUN   = 2'b00,
        MCCRTC_WAIT  = 2'b01,
        MCCRTC_AHALT = 2'b11,
        MCCRTC_HALT  = 2'b10
    } mccrtc_power_t;

    typedef struct packed {
        logic       clock_out_select;
        logic [1:0] slow_divider_sel;
        logic       slow_mode_select;
        logic [1:0] time_base_sel;
        logic       overflow_irq_enable;
        logic       overflow_flag;
    } mccrtc_ccs_t;

    typedef struct packed {
        logic [3:0] reserved;
        logic       adc_sample_stretch;
        logic       adc_irq_enable;
        logic [1:0] beep_tone_sel;
    } mccrtc_beep_t;

    typedef struct packed {
        logic       halt_req;
        logic       wake_req;
        logic       wake_halt;
        logic       wait_req;
    } mccrtc_pwr_cmd_t;

endpackage

// ---- core/mccrtc_divider.sv ----
// Free dividing counter that toggles a square wave at a given half period.
`include "mccrtc_cfg.svh"

module mccrtc_divider
    import mccrtc_pkg::*;
#(
    parameter int CNT_W = 18
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Control
    input  wire logic             run,
    input  wire logic             enable,
    input  wire logic [CNT_W-1:0] half_period,
    // Status
    output logic                  wave,
    output logic                  wrap
);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             wave_reg;
    logic             last_w;

    assign last_w   = (cnt_reg >= half_period - CNT_W'(1));
    assign cnt_next = !enable ? '0 :
                      !run    ? cnt_reg :
                      last_w  ? '0 : cnt_reg + CNT_W'(1);
    assign wave = wave_reg;
    assign wrap = enable && run && last_w;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg  <= '0;
            wave_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            wave_reg <= !enable ? 1'b0 : (wrap ? ~wave_reg : wave_reg);
        end
    end

endmodule

// ---- verification/mccrtc_pin_watch.sv ----
// Pin watcher for the devices fed by the clock-out and beep pins.
module mccrtc_pin_watch (
    // Clock and pins
    input  wire logic aclk,
    input  wire logic beep_pin,
    input  wire logic clock_out_pin,
    // Measurements
    output int        beep_hi_len,
    output int        beep_lo_len,
    output int        beep_edges,
    output int        co_edges
);
    timeunit 1ns;
    timeprecision 1ps;
    int   run_len;
    logic beep_d;
    logic co_d;
    initial begin
        {beep_hi_len, beep_lo_len, beep_edges, co_edges, run_len} = '0;
        {beep_d, co_d} = 2'b11;
    end
    // A load only counts edges and run lengths, as a buzzer or scope would.
    always @(posedge aclk) begin
        run_len++;
        if (clock_out_pin !== co_d) co_edges++;
        if (beep_pin !== beep_d) begin
            beep_edges++;
            if (beep_d) beep_hi_len = run_len;
            else beep_lo_len = run_len;
            run_len = 0;
        end
        beep_d = beep_pin;
        co_d = clock_out_pin;
    end
endmodule

// ---- verification/main_clock_rtc_beeper_bench.sv ----
// Self-checking bench for the main clock controller.
`include "mccrtc_cfg.svh"

module main_clock_rtc_beeper_bench;
    import mccrtc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [9:0] A_CCS = 10'(`MCC_IDX_CCS * 4);
    localparam logic [9:0] A_BEEP = 10'(`MCC_IDX_BEEP * 4);
    localparam int HALF [1:3] = '{4, 8, 16};
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, irq_d = 1'b0;
    logic [9:0] awaddr = '0, araddr = '0;
    logic [3:0] wstrb = 4'hF;
    logic [31:0] wdata = '0, rdata;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, cpu_en, co_o, co_oe;
    logic bp_o, bp_oe, irq, ahalt, fhalt, stretch, adcie, co_pin, bp_pin;
    mccrtc_pwr_cmd_t pwr = '0;
    int err_count = 0, checked = 0, cyc = 0, co_e, bp_e, bp_hi, bp_lo;
    int stamps[$];
    // Released pins are pulled up.
    assign co_pin = co_oe ? co_o : 1'b1;
    assign bp_pin = bp_oe ? bp_o : 1'b1;

    mccrtc_main_clock_rtc #(.TB_PERIOD0(16), .TB_PERIOD3(200),
        .BEEP_HALF1(4), .BEEP_HALF2(8), .BEEP_HALF3(16)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pwr_cmd(pwr), .cpu_clk_en(cpu_en),
        .clock_out_pin_o(co_o), .clock_out_pin_oe(co_oe),
        .beep_pin_o(bp_o), .beep_pin_oe(bp_oe), .overflow_irq(irq),
        .active_halt(ahalt), .full_halt(fhalt),
        .adc_sample_stretch(stretch), .adc_irq_enable(adcie));
    mccrtc_pin_watch u_watch (.aclk(aclk), .beep_pin(bp_pin),
        .clock_out_pin(co_pin), .beep_hi_len(bp_hi), .beep_lo_len(bp_lo),
        .beep_edges(bp_e), .co_edges(co_e));

    initial forever #5 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        irq_d <= irq;
        if (irq && !irq_d) stamps.push_back(cyc);
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, got);
        checked++;
        if (got !== e) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", n, e, got);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic ta, tw, b;
        logic [1:0] r;
        {ta, tw} = 2'b00;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            @(negedge aclk);
            ta = ta || awready;
            tw = tw || wready;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!(ta && tw));
        do begin
            @(negedge aclk);
            b = bvalid;
            r = bresp;
            @(posedge aclk);
        end while (!b);
        bready <= 1'b0;
        chk("bresp", 32'h0, 32'(r));
    endtask
    task automatic rc(input logic [9:0] a, input logic [7:0] e,
                      input logic [1:0] er);
        logic t;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do begin
            @(negedge aclk);
            t = arready;
            @(posedge aclk);
        end while (!t);
        arvalid <= 1'b0;
        do begin
            @(negedge aclk);
            {t, d, r} = {rvalid, rdata, rresp};
            @(posedge aclk);
        end while (!t);
        rready <= 1'b0;
        chk("rdata", {24'h0, e}, d);
        chk("rresp", 32'(er), 32'(r));
    endtask
    task automatic pulse(input logic [3:0] c);
        @(posedge aclk);
        pwr <= mccrtc_pwr_cmd_t'(c);
        @(posedge aclk);
        pwr <= '0;
        repeat (2) @(negedge aclk);
    endtask

    initial begin
        int n;
        int m;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rc(A_CCS, 8'h00, 2'b00);
        rc(A_BEEP, 8'h00, 2'b00);
        rc(10'h000, 8'h00, 2'b10);
        wr(A_BEEP, 8'h0C);
        repeat (2) @(negedge aclk);
        chk("adc_sample_stretch", 1, stretch);
        chk("adc_irq_enable", 1, adcie);
        for (int t = 1; t < 4; t++) begin
            wr(A_BEEP, 8'(t));
            repeat (80) @(posedge aclk);
            chk("beep_high", HALF[t], bp_hi);
            chk("beep_low", HALF[t], bp_lo);
        end
        // A write with the low byte strobe clear must leave the register.
        wstrb <= 4'h0;
        wr(A_BEEP, 8'h0F);
        wstrb <= 4'hF;
        rc(A_BEEP, 8'h03, 2'b00);
        for (int k = 0; k < 5; k++) begin
            wr(A_CCS, (k == 4) ? 8'h00 : 8'(8'h10 | (k << 5)));
            repeat (4) @(negedge aclk);
            n = 0;
            repeat (64) @(negedge aclk) n += cpu_en;
            chk("cpu_clk_en", (k == 4) ? 64 : 64 >> (k + 1), n);
        end
        wr(A_CCS, 8'h80);
        repeat (3) @(negedge aclk);
        n = co_e;
        repeat (8) @(negedge aclk);
        chk("clock_out_edges", 8, co_e - n);
        // The tick after a time base change still uses the old period.
        wr(A_CCS, 8'h02);
        for (int i = 0; i < 4; i++) begin
            while (stamps.size() <= i) @(posedge aclk);
            rc(A_CCS, (i < 2) ? 8'h03 : 8'h0F, 2'b00);
            if (i == 1) wr(A_CCS, 8'h0E);
        end
        rc(A_CCS, 8'h0E, 2'b00);
        chk("old_period", 16, stamps[2] - stamps[1]);
        chk("new_period", 200, stamps[3] - stamps[2]);
        wr(A_CCS, 8'h8E);
        pulse(4'b1000);
        chk("active_halt", 1, ahalt);
        // Let the last toggle from before the halt reach the watcher.
        repeat (2) @(negedge aclk);
        {n, m} = {co_e, bp_e};
        repeat (40) @(negedge aclk);
        chk("clock_out_edges", 0, co_e - n);
        chk("beep_edges", 1, 32'(bp_e - m > 1));
        wr(A_BEEP, 8'h00);
        while (ahalt === 1'b1) @(negedge aclk);
        chk("wake_tick", 200, stamps[4] - stamps[3]);
        rc(A_BEEP, 8'h03, 2'b00);
        wr(A_CCS, 8'h0C);
        pulse(4'b1000);
        chk("full_halt", 1, fhalt);
        pulse(4'b0100);
        chk("full_halt", 1, fhalt);
        pulse(4'b0010);
        chk("full_halt", 0, fhalt);
        give_verdict();
    end
endmodule
